// [pkg/tef_pkg.sv]
// Purpose: shared constants and types of the timer event and flag unit
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes: offsets are byte addresses
package tef_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTL_SLAVE = 8'h08;
  localparam logic [7:0] OFF_DMA_IRQ_EN = 8'h0c;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] OFF_SOFT_EVENT = 8'h14;
  localparam logic [7:0] OFF_CHAN_CTL_LOW = 8'h18;
  localparam logic [7:0] OFF_CHAN_CTL_HIGH = 8'h1c;
  localparam logic [7:0] OFF_MODE_CTL = 8'h20;
  localparam logic [7:0] OFF_CAPTURE0 = 8'h24;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int BIT_UPDATE = 0;
  localparam int BIT_CHAN0 = 1;
  localparam int BIT_TRIGGER = 6;
  localparam int BIT_UPD_DMA = 8;
  localparam int BIT_CHAN0_DMA = 9;
  localparam int BIT_OVER0 = 9;
  localparam int BIT_TRIG_DMA = 14;
  localparam int BIT_QJUMP = 16;
  localparam int BIT_QDISC = 17;
  localparam int BIT_EXTRA0 = 28;
  localparam int BIT_SYNC_START = 7;
  localparam int BIT_DMA_SRC = 3;
  localparam int BIT_UPD_SRC = 2;
  localparam int BIT_QJUMP_DET = 0;
  localparam int BIT_QDISC_DET = 1;
  localparam int BIT_PAUSE = 2;
  localparam int BIT_SLAVE_EN = 3;
  localparam int BIT_DOWN = 4;
  localparam int BIT_COMPOSITE0 = 8;
  // channel mode field: low two bits at 8*n, bit 2 at 30+n in each pair
  localparam logic [2:0] MODE_OUTPUT = 3'b000;
  localparam logic [3:0] CMP_PWM0 = 4'b0110;
  localparam logic [3:0] CMP_PWM1 = 4'b0111;
  localparam logic [31:0] FLAG_MASK = 32'hf003_1e5f;
  localparam logic [31:0] SOFT_MASK = 32'hf000_005f;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // hardware events from the timer core, one-cycle pulses
  typedef struct packed {
    logic [3:0] extraCmp;
    logic quadDisc;
    logic quadJump;
    logic [3:0] capCmp;
    logic trigEdgeActive;
    logic trigEdgeAny;
    logic overflow;
    logic slaveUpdate;
  } tef_events_type;

  // requests to the timer core
  typedef struct packed {
    logic counterClear;
    logic counterLoadReload;
    logic prescalerClear;
    logic [3:0] captureNow;
    logic syncStart;
  } tef_core_type;
endpackage : tef_pkg

// [design/tef_sync3.sv]
// Purpose: three-stage synchroniser for a pin level
// Assumes: single clock, synchronous active-low reset
// Notes: output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module tef_sync3
  import tef_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  // accept a change only when settled
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      out_ff <= s3_ff;
    end
  end
  assign dout = out_ff;
endmodule : tef_sync3
`default_nettype wire

// [design/tef_quad_detect.sv]
// Purpose: quadrature jump and disconnection detector
// Assumes: synchronised phase levels
// Notes: disconnection is a phase level held past a timeout
`timescale 1ns/100ps
`default_nettype none
module tef_quad_detect
  import tef_pkg::*;
#(
  parameter logic [15:0] DISC_LIMIT = 16'h0fff
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // phases and enables
  input wire logic phaseA,
  input wire logic phaseB,
  input wire logic jumpDetEn,
  input wire logic discDetEn,
  // event pulses
  output logic jumpEvt,
  output logic discEvt
);
  logic prevA_ff;
  logic prevB_ff;
  logic [15:0] idle_ff;
  logic jump_ff;
  logic disc_ff;
  logic changeA;
  logic changeB;
  assign changeA = phaseA ^ prevA_ff;
  assign changeB = phaseB ^ prevB_ff;
  // both phases toggling at once is a jump; long silence a disconnect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevA_ff <= 1'b0;
      prevB_ff <= 1'b0;
      idle_ff <= 16'h0000;
      jump_ff <= 1'b0;
      disc_ff <= 1'b0;
    end else begin
      prevA_ff <= phaseA;
      prevB_ff <= phaseB;
      jump_ff <= jumpDetEn && changeA && changeB;
      if (changeA || changeB || !discDetEn) begin
        idle_ff <= 16'h0000;
      end else if (idle_ff != DISC_LIMIT) begin
        idle_ff <= idle_ff + 16'h0001;
      end
      disc_ff <= discDetEn && (idle_ff == DISC_LIMIT - 16'h0001);
    end
  end
  assign jumpEvt = jump_ff;
  assign discEvt = disc_ff;
endmodule : tef_quad_detect
`default_nettype wire

// [design/tef_unit.sv]
// Purpose: event flags, interrupt and DMA requests of a timer
// Assumes: AXI4-Lite slave, 40 MHz clock, sync active-low reset
// Notes: software events self-clear the cycle after the write
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - sync start set makes trigger input the counter start event
// - interrupt enables: update 0, channels 1-4, trigger 6, 16, 17, 28-31
// - DMA enables: update 8, channels 9-12, trigger 14; gate requests
// - extra compare interrupt enables act only in composite PWM mode
// - quadrature interrupt enables act only with their detection enabled
// - channel flag set by capture (input) or compare (output) event
// - reading capture value clears the input channel flag
// - over-capture set when capture hits an already set channel flag
// - trigger flag: any edge in pause mode, active edge otherwise
// - update flag set on update event (only overflow with update source set), held until software clears
// - extra compare flag set by hardware compare only in composite PWM mode
// - quadrature jump and disconnect flags set by enabled detection
// - channel soft event sets flag; in input mode captures, sets over-capture if flag already set
// - trigger soft event sets trigger flag, self-clears
// - update soft event clears or reloads counter, clears prescaler
// - extra compare soft event sets extra flag, self-clears
// - DMA source select picks channel event or update for requests
// - update source set: only overflow raises update irq or DMA
module tef_unit
  import tef_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer core side
  input wire tef_events_type hwEvents,
  input wire logic [31:0] captureValue0,
  input wire logic triggerIn,
  input wire logic quadPhaseA,
  input wire logic quadPhaseB,
  output tef_core_type coreReq,
  // requests
  output logic timerIrq,
  output logic [5:0] dmaReq
);
  // ----------------------------------------------------------------------
  // registers and bus state
  // ----------------------------------------------------------------------
  logic [31:0] enable_ff;
  logic [31:0] flags_ff;
  logic [31:0] chanLow_ff;
  logic [31:0] chanHigh_ff;
  logic [31:0] slave_ff;
  logic [31:0] mode_ff;
  logic [31:0] soft_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic awHave_ff;
  logic wHave_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic arReady_ff;
  logic rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0] rResp_ff;
  logic irq_ff;
  logic [5:0] dma_ff;
  tef_core_type core_ff;
  logic trigSync;
  logic trigPrev_ff;
  logic phaseA;
  logic phaseB;
  logic quadJumpEvt;
  logic quadDiscEvt;

  // full word access only; partial strobes are refused
  function automatic logic isInput(input logic [31:0] lo, hi, int ch);
    logic [2:0] m;
    m = 3'b000;
    case (ch)
      0: m = {lo[30], lo[1:0]};
      1: m = {lo[31], lo[9:8]};
      2: m = {hi[30], hi[1:0]};
      default: m = {hi[31], hi[9:8]};
    endcase
    return m != MODE_OUTPUT;
  endfunction : isInput

  function automatic logic isComposite(input logic [31:0] lo, hi,
                                       input logic [31:0] md, int ch);
    logic [3:0] c;
    c = 4'h0;
    case (ch)
      0: c = {lo[16], lo[6:4]};
      1: c = {lo[24], lo[14:12]};
      2: c = {hi[16], hi[6:4]};
      default: c = {hi[24], hi[14:12]};
    endcase
    return md[BIT_COMPOSITE0 + ch] && !isInput(lo, hi, ch) &&
           (c == CMP_PWM0 || c == CMP_PWM1);
  endfunction : isComposite

  // ----------------------------------------------------------------------
  // pin synchronisers and quadrature detection
  // ----------------------------------------------------------------------
  tef_sync3 uSyncTrig (.clk(clk), .rst_n(rst_n), .din(triggerIn),
                       .dout(trigSync));
  tef_sync3 uSyncA (.clk(clk), .rst_n(rst_n), .din(quadPhaseA),
                    .dout(phaseA));
  tef_sync3 uSyncB (.clk(clk), .rst_n(rst_n), .din(quadPhaseB),
                    .dout(phaseB));
  tef_quad_detect uQuad (
    .clk(clk), .rst_n(rst_n), .phaseA(phaseA), .phaseB(phaseB),
    .jumpDetEn(mode_ff[BIT_QJUMP_DET]), .discDetEn(mode_ff[BIT_QDISC_DET]),
    .jumpEvt(quadJumpEvt), .discEvt(quadDiscEvt)
  );

  // ----------------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------------
  logic wrFire;
  logic wrFull;
  logic rdFire;
  logic rdCapture0;
  assign wrFull = (s_axi_wstrb == 4'hf);
  assign wrFire = awHave_ff && wHave_ff && !bValid_ff;

  // address and data are taken in either order, one write at a time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= RESET_WORD;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !awHave_ff && !bValid_ff) begin
        awHave_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_ff && !bValid_ff) begin
        wHave_ff <= 1'b1;
        wData_ff <= wrFull ? s_axi_wdata : 32'hffff_ffff;
        bResp_ff <= wrFull ? RESP_OKAY : RESP_SLVERR;
      end
      if (wrFire) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        bValid_ff <= 1'b1;
        if (awAddr_ff[1:0] != 2'b00 || awAddr_ff > OFF_CAPTURE0) begin
          bResp_ff <= RESP_SLVERR;
        end
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awHave_ff && !bValid_ff;
  assign s_axi_wready = !wHave_ff && !bValid_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;

  logic wrOk;
  assign wrOk = wrFire && bResp_ff == RESP_OKAY;

  // plain read/write control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_ff <= RESET_WORD;
      chanLow_ff <= RESET_WORD;
      chanHigh_ff <= RESET_WORD;
      slave_ff <= RESET_WORD;
      mode_ff <= RESET_WORD;
    end else if (wrOk) begin
      case (awAddr_ff)
        OFF_DMA_IRQ_EN: enable_ff <= wData_ff & 32'hf003_5f5f;
        OFF_CHAN_CTL_LOW: chanLow_ff <= wData_ff;
        OFF_CHAN_CTL_HIGH: chanHigh_ff <= wData_ff;
        OFF_CTL_SLAVE: slave_ff <= wData_ff & 32'h0000_008c;
        OFF_MODE_CTL: mode_ff <= wData_ff & 32'h0000_0f1f;
        default: ;
      endcase
    end
  end

  // soft event bits live one cycle, then clear themselves
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_ff <= RESET_WORD;
    end else if (wrOk && awAddr_ff == OFF_SOFT_EVENT) begin
      soft_ff <= wData_ff & SOFT_MASK;
    end else begin
      soft_ff <= RESET_WORD;
    end
  end

  // ----------------------------------------------------------------------
  // event gathering
  // ----------------------------------------------------------------------
  logic [31:0] setEv;
  logic [31:0] keepMask;
  logic updEv;
  logic updCountsIrq;
  logic trigEv;
  logic [3:0] chanEv;
  logic [3:0] inMode;
  logic [3:0] compMode;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      inMode[i] = isInput(chanLow_ff, chanHigh_ff, i);
      compMode[i] = isComposite(chanLow_ff, chanHigh_ff, mode_ff, i);
    end
  end
  assign trigEv = (mode_ff[BIT_SLAVE_EN] &&
                   (mode_ff[BIT_PAUSE] ? (trigSync ^ trigPrev_ff)
                                       : (trigSync && !trigPrev_ff)))
                  || soft_ff[BIT_TRIGGER];
  assign updEv = hwEvents.overflow || hwEvents.slaveUpdate ||
                 soft_ff[BIT_UPDATE];
  assign updCountsIrq = slave_ff[BIT_UPD_SRC] ? hwEvents.overflow
                                              : updEv;
  assign chanEv = hwEvents.capCmp | soft_ff[BIT_CHAN0 +: 4];

  always_comb begin
    setEv = RESET_WORD;
    setEv[BIT_UPDATE] = updCountsIrq;
    setEv[BIT_CHAN0 +: 4] = chanEv;
    setEv[BIT_TRIGGER] = trigEv;
    setEv[BIT_OVER0 +: 4] = chanEv & inMode & flags_ff[BIT_CHAN0 +: 4];
    setEv[BIT_QJUMP] = quadJumpEvt;
    setEv[BIT_QDISC] = quadDiscEvt;
    setEv[BIT_EXTRA0 +: 4] = (hwEvents.extraCmp & compMode) |
                             soft_ff[BIT_EXTRA0 +: 4];
  end

  // ----------------------------------------------------------------------
  // flags: write 0 clears, capture read clears, hardware set wins
  // ----------------------------------------------------------------------
  always_comb begin
    keepMask = 32'hffff_ffff;
    if (wrOk && awAddr_ff == OFF_EVENT_FLAGS) begin
      keepMask = wData_ff;
    end
    if (rdCapture0 && inMode[0]) begin
      keepMask[BIT_CHAN0] = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_ff <= RESET_WORD;
    end else begin
      flags_ff <= ((flags_ff & keepMask) | setEv) & FLAG_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt and dma requests
  // ----------------------------------------------------------------------
  logic [31:0] irqGate;
  always_comb begin
    irqGate = enable_ff & FLAG_MASK;
    irqGate[BIT_OVER0 +: 4] = 4'h0;
    irqGate[BIT_QJUMP] = enable_ff[BIT_QJUMP] &&
                         mode_ff[BIT_QJUMP_DET];
    irqGate[BIT_QDISC] = enable_ff[BIT_QDISC] &&
                         mode_ff[BIT_QDISC_DET];
    irqGate[BIT_EXTRA0 +: 4] = enable_ff[BIT_EXTRA0 +: 4] & compMode;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
      trigPrev_ff <= 1'b0;
    end else begin
      irq_ff <= |(flags_ff & irqGate);
      trigPrev_ff <= trigSync;
    end
  end

  // dma pulses: [0] update, [4:1] channels, [5] trigger
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_ff <= 6'h00;
    end else begin
      dma_ff[0] <= updCountsIrq && enable_ff[BIT_UPD_DMA];
      dma_ff[4:1] <= (slave_ff[BIT_DMA_SRC] ? {4{updCountsIrq}} : chanEv)
                     & enable_ff[BIT_CHAN0_DMA +: 4];
      dma_ff[5] <= trigEv && enable_ff[BIT_TRIG_DMA];
    end
  end

  // requests to the counter core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_ff <= '0;
    end else begin
      core_ff.counterClear <= soft_ff[BIT_UPDATE] &&
                              !mode_ff[BIT_DOWN];
      core_ff.counterLoadReload <= soft_ff[BIT_UPDATE] &&
                                   mode_ff[BIT_DOWN];
      core_ff.prescalerClear <= soft_ff[BIT_UPDATE];
      core_ff.captureNow <= soft_ff[BIT_CHAN0 +: 4] & inMode;
      core_ff.syncStart <= slave_ff[BIT_SYNC_START] &&
                           trigSync && !trigPrev_ff;
    end
  end
  assign coreReq = core_ff;
  assign timerIrq = irq_ff;
  assign dmaReq = dma_ff;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign rdFire = s_axi_arvalid && arReady_ff;
  assign rdCapture0 = rdFire && s_axi_araddr == OFF_CAPTURE0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
      rData_ff <= RESET_WORD;
      rResp_ff <= RESP_OKAY;
    end else if (rdFire) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b1;
      rResp_ff <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTL_SLAVE: rData_ff <= slave_ff;
        OFF_DMA_IRQ_EN: rData_ff <= enable_ff;
        OFF_EVENT_FLAGS: rData_ff <= flags_ff;
        OFF_SOFT_EVENT: rData_ff <= RESET_WORD;
        OFF_CHAN_CTL_LOW: rData_ff <= chanLow_ff;
        OFF_CHAN_CTL_HIGH: rData_ff <= chanHigh_ff;
        OFF_MODE_CTL: rData_ff <= mode_ff;
        OFF_CAPTURE0: rData_ff <= captureValue0;
        default: begin
          rData_ff <= RESET_WORD;
          rResp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      rValid_ff <= 1'b0;
      arReady_ff <= 1'b1;
    end
  end
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence softUpdWrite;
    wrOk && awAddr_ff == OFF_SOFT_EVENT && wData_ff[BIT_UPDATE];
  endsequence
  upd_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    updCountsIrq |=> flags_ff[BIT_UPDATE])
    else $error("update flag not set");
  soft_self_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    softUpdWrite ##1 1'b1 |=> soft_ff == RESET_WORD)
    else $error("soft event did not clear");
  upd_src_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    slave_ff[BIT_UPD_SRC] && !hwEvents.overflow |=> !dma_ff[0])
    else $error("update dma without overflow");
  irq_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(flags_ff & irqGate) |=> timerIrq)
    else $error("irq missing");
  over_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    chanEv[0] && inMode[0] && flags_ff[BIT_CHAN0] |=> flags_ff[BIT_OVER0])
    else $error("over-capture missed");
  cap_read_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdCapture0 && inMode[0] && !chanEv[0] |=> !flags_ff[BIT_CHAN0])
    else $error("capture read did not clear");
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrOk && awAddr_ff == OFF_EVENT_FLAGS && trigEv |=> flags_ff[BIT_TRIGGER])
    else $error("clear beat set");
  extra_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    hwEvents.extraCmp[0] && !compMode[0] && !soft_ff[BIT_EXTRA0] &&
    !flags_ff[BIT_EXTRA0] |=> !flags_ff[BIT_EXTRA0])
    else $error("extra flag outside composite");
  dma_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enable_ff[BIT_TRIG_DMA] |=> !dma_ff[5])
    else $error("trigger dma while disabled");
endmodule : tef_unit
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench for the timer event and flag unit
// Assumes: AXI4-Lite register access, 40 MHz clock, sync reset
// Notes: sticky monitors catch the one-cycle request pulses
`timescale 1ns/100ps
`default_nettype none
module testbench
  import tef_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, triggerIn = 1'b0;
  logic quadPhaseA = 1'b0, quadPhaseB = 1'b0, timerIrq;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdVal;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  tef_events_type hwEvents = '0;
  tef_core_type coreReq, cSeen = '0;
  logic [5:0] dmaReq, dSeen = '0;
  logic [31:0] capVal = 32'h1234_abcd;
  int error_cnt = 0, tests_run = 0;

  always #12.5 clk = ~clk;

  // pulses are one cycle wide, so keep a sticky copy
  always @(posedge clk) begin
    cSeen <= cSeen | coreReq;
    dSeen <= dSeen | dmaReq;
  end

  tef_unit i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .hwEvents(hwEvents), .captureValue0(capVal), .triggerIn(triggerIn),
    .quadPhaseA(quadPhaseA), .quadPhaseB(quadPhaseB), .coreReq(coreReq),
    .timerIrq(timerIrq), .dmaReq(dmaReq));

  // ----------------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // ready is sampled mid-cycle, so no race with the edge updates
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    logic pa, pw, h;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do begin
      @(negedge clk);
      h = s_axi_bvalid;
      resp = s_axi_bresp;
    end while (!h);
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic h;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clk);
      h = s_axi_arready;
      @(posedge clk);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      h = s_axi_rvalid;
      rdVal = s_axi_rdata;
      resp = s_axi_rresp;
    end while (!h);
    @(posedge clk);
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rdVal);
  endtask : rc

  task automatic irq(input logic e);
    @(negedge clk);
    chk("irq", {31'h0, e}, {31'h0, timerIrq});
  endtask : irq

  // soft events land a few cycles after the write
  task automatic pulse(input tef_events_type e);
    @(posedge clk);
    hwEvents <= e;
    @(posedge clk);
    hwEvents <= '0;
    repeat (6) @(posedge clk);
  endtask : pulse

  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_regs;
    rc(OFF_DMA_IRQ_EN, RESET_WORD);
    rc(OFF_EVENT_FLAGS, RESET_WORD);
    rc(OFF_SOFT_EVENT, RESET_WORD);
    rc(OFF_CHAN_CTL_LOW, RESET_WORD);
    rd(8'h40);
    chk("bad addr", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(OFF_DMA_IRQ_EN, 32'hffff_ffff, 4'h3);
    chk("half word", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rc(OFF_DMA_IRQ_EN, RESET_WORD);
    wr(OFF_DMA_IRQ_EN, 32'hf003_5f5f);
    rc(OFF_DMA_IRQ_EN, 32'hf003_5f5f);
  endtask : s_regs

  task automatic s_flags;
    tef_events_type ev;
    ev = '0;
    ev.overflow = 1'b1;
    pulse(ev);
    rc(OFF_EVENT_FLAGS, 32'h1);
    irq(1'b1);
    chk("upd dma", 32'h1, {31'h0, dSeen[0]});
    wr(OFF_EVENT_FLAGS, 32'hffff_ffff);
    rc(OFF_EVENT_FLAGS, 32'h1);
    wr(OFF_EVENT_FLAGS, 32'h0);
    rc(OFF_EVENT_FLAGS, 32'h0);
    irq(1'b0);
    wr(OFF_SOFT_EVENT, 32'h40);
    pulse('0);
    rc(OFF_EVENT_FLAGS, 32'h40);
    rc(OFF_SOFT_EVENT, 32'h0);
    chk("trig dma", 32'h1, {31'h0, dSeen[5]});
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_flags

  task automatic s_chan;
    wr(OFF_CHAN_CTL_LOW, 32'h1);
    wr(OFF_SOFT_EVENT, 32'h2);
    pulse('0);
    wr(OFF_SOFT_EVENT, 32'h2);
    pulse('0);
    rc(OFF_EVENT_FLAGS, 32'h202);
    chk("capture", 32'h1, {31'h0, cSeen.captureNow[0]});
    chk("ch dma", 32'h1, {31'h0, dSeen[1]});
    rc(OFF_CAPTURE0, capVal);
    rc(OFF_EVENT_FLAGS, 32'h200);
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_chan

  task automatic s_update;
    tef_events_type ev;
    ev = '0;
    ev.overflow = 1'b1;
    wr(OFF_CTL_SLAVE, 32'h4);
    wr(OFF_SOFT_EVENT, 32'h1);
    pulse('0);
    chk("cnt clear", 32'h1, {31'h0, cSeen.counterClear});
    chk("psc clear", 32'h1, {31'h0, cSeen.prescalerClear});
    rc(OFF_EVENT_FLAGS, 32'h0);
    pulse(ev);
    rc(OFF_EVENT_FLAGS, 32'h1);
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_update

  task automatic s_extra;
    tef_events_type ev;
    ev = '0;
    ev.extraCmp = 4'h1;
    wr(OFF_CHAN_CTL_LOW, 32'h0);
    pulse(ev);
    rc(OFF_EVENT_FLAGS, 32'h0);
    wr(OFF_MODE_CTL, 32'h100);
    wr(OFF_CHAN_CTL_LOW, 32'h60);
    pulse(ev);
    rc(OFF_EVENT_FLAGS, 32'h1000_0000);
    irq(1'b1);
    wr(OFF_EVENT_FLAGS, 32'h0);
    wr(OFF_SOFT_EVENT, 32'h1000_0000);
    pulse('0);
    rc(OFF_EVENT_FLAGS, 32'h1000_0000);
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_extra

  // both phases move at once, which is a jump
  task automatic s_pins;
    wr(OFF_MODE_CTL, 32'h1);
    quadPhaseA <= 1'b1;
    quadPhaseB <= 1'b1;
    pulse('0);
    rc(OFF_EVENT_FLAGS, 32'h1_0000);
    irq(1'b1);
    wr(OFF_EVENT_FLAGS, 32'h0);
    wr(OFF_CTL_SLAVE, 32'h80);
    wr(OFF_MODE_CTL, 32'h8);
    triggerIn <= 1'b1;
    pulse('0);
    chk("sync start", 32'h1, {31'h0, cSeen.syncStart});
    rc(OFF_EVENT_FLAGS, 32'h40);
    wr(OFF_EVENT_FLAGS, 32'h0);
    wr(OFF_MODE_CTL, 32'hc);
    triggerIn <= 1'b0;
    pulse('0);
    rc(OFF_EVENT_FLAGS, 32'h40);
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_pins

  // silent phases trip the disconnect timeout; update feeds channel dma
  task automatic s_dma;
    wr(OFF_MODE_CTL, 32'h2);
    repeat (4200) @(posedge clk);
    rc(OFF_EVENT_FLAGS, 32'h2_0000);
    irq(1'b1);
    wr(OFF_EVENT_FLAGS, 32'h0);
    wr(OFF_CTL_SLAVE, 32'h8);
    wr(OFF_MODE_CTL, 32'h10);
    wr(OFF_SOFT_EVENT, 32'h1);
    pulse('0);
    chk("reload", 32'h1, {31'h0, cSeen.counterLoadReload});
    chk("upd ch dma", 32'h7, {29'h0, dSeen[4:2]});
    rc(OFF_EVENT_FLAGS, 32'h1);
    wr(OFF_EVENT_FLAGS, 32'h0);
  endtask : s_dma

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_flags();
    s_chan();
    s_update();
    s_extra();
    s_pins();
    s_dma();
    report_and_stop();
  end

  // watchdog, well above the few thousand cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
